// ### common/dsp_dalu_pkg.sv
/*
  Shared constants for the data arithmetic datapath: widths, operation
  codes, register and operand selects, rounding and limiting values.
  Assumes every user imports the whole package.
*/
package dsp_dalu_pkg;
  // ==========================================================
  // Widths
  localparam int WORD_W = 24;
  localparam int EXT_W = 8;
  localparam int ACC_W = 56;
  localparam int SHIFT_W = 6;

  // ==========================================================
  // Operations
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_MPY = 4'h1,
    OP_MAC = 4'h2,
    OP_ADD = 4'h3,
    OP_SUB = 4'h4,
    OP_TFR = 4'h5,
    OP_CLR = 4'h6,
    OP_SHIFT = 4'h7,
    OP_NORM = 4'h8,
    OP_RND = 4'h9
  } dalu_op_e;

  // Multiplier operand signedness
  localparam logic [1:0] SGN_SS = 2'h0;
  localparam logic [1:0] SGN_SU = 2'h1;
  localparam logic [1:0] SGN_UU = 2'h2;

  // Bus shifter scaling
  localparam logic [1:0] SCALE_NONE = 2'h0;
  localparam logic [1:0] SCALE_DOWN = 2'h1;
  localparam logic [1:0] SCALE_UP = 2'h2;

  // ==========================================================
  // Bus register selects
  localparam logic [3:0] SEL_FIRST_INPUT_HIGH = 4'h0;
  localparam logic [3:0] SEL_FIRST_INPUT_LOW = 4'h1;
  localparam logic [3:0] SEL_SECOND_INPUT_HIGH = 4'h2;
  localparam logic [3:0] SEL_SECOND_INPUT_LOW = 4'h3;
  localparam logic [3:0] SEL_ACC_ONE_EXTENSION = 4'h4;
  localparam logic [3:0] SEL_ACC_ONE_HIGH = 4'h5;
  localparam logic [3:0] SEL_ACC_ONE_LOW = 4'h6;
  localparam logic [3:0] SEL_ACC_TWO_EXTENSION = 4'h7;
  localparam logic [3:0] SEL_ACC_TWO_HIGH = 4'h8;
  localparam logic [3:0] SEL_ACC_TWO_LOW = 4'h9;
  localparam logic [3:0] SEL_ACC_ONE = 4'ha;
  localparam logic [3:0] SEL_ACC_TWO = 4'hb;
  localparam logic [3:0] SEL_ACC_ONE_LIM_LOW = 4'hc;
  localparam logic [3:0] SEL_ACC_TWO_LIM_LOW = 4'hd;

  // Operand sources
  localparam logic [2:0] SRC_FIRST_PAIR = 3'h4;
  localparam logic [2:0] SRC_SECOND_PAIR = 3'h5;
  localparam logic [2:0] SRC_ACC_ONE = 3'h6;
  localparam logic [2:0] SRC_ACC_TWO = 3'h7;

  // ==========================================================
  // Reset, rounding and limiting values
  localparam logic [23:0] WORD_RST = 24'h000000;
  localparam logic [55:0] ACC_RST = 56'h00000000000000;
  localparam logic [23:0] MODE16_MASK = 24'hffff00;
  localparam logic [55:0] RND_ADD_24 = 56'h00000000800000;
  localparam logic [55:0] RND_MASK_24 = 56'hffffffff000000;
  localparam logic [55:0] RND_ADD_16 = 56'h00000080000000;
  localparam logic [55:0] RND_MASK_16 = 56'hffffff00000000;
  localparam logic [23:0] LIM_POS_HIGH = 24'h7fffff;
  localparam logic [23:0] LIM_POS_LOW = 24'hffffff;
  localparam logic [23:0] LIM_NEG_HIGH = 24'h800000;
  localparam logic [23:0] LIM_NEG_LOW = 24'h000000;
endpackage

// ### hw/dalu_bus_limiter.sv
/*
  One data bus shifter/limiter: scales an accumulator and saturates it
  to a 48-bit bus operand. Purely combinational; the caller registers.
*/
`timescale 1ns/1ns
`default_nettype none
module dalu_bus_limiter
  import dsp_dalu_pkg::*;
(
  // Accumulator and mode
  input wire logic [55:0] i_acc,
  input wire logic [1:0] i_scale,
  input wire logic i_mode16,
  // Bus words
  output logic [23:0] o_high,
  output logic [23:0] o_low,
  output logic o_limited
);
  logic [55:0] scaled;
  logic ovf;

  always_comb begin
    scaled = i_acc;
    if (i_scale == SCALE_DOWN) begin
      scaled = {i_acc[55], i_acc[55:1]};
    end else if (i_scale == SCALE_UP) begin
      scaled = {i_acc[54:0], 1'b0};
    end
    // Ext bits not a pure sign copy means the value will not fit
    ovf = (scaled[55:47] != {9{scaled[55]}});
    o_limited = ovf;
    if (!ovf) begin
      o_high = scaled[47:24];
      o_low = scaled[23:0];
    end else if (scaled[55]) begin
      o_high = LIM_NEG_HIGH;
      o_low = LIM_NEG_LOW;
    end else begin
      o_high = LIM_POS_HIGH;
      o_low = LIM_POS_LOW;
    end
    if (i_mode16) begin
      o_high = o_high & MODE16_MASK;
      o_low = o_low & MODE16_MASK;
    end
  end
endmodule
`default_nettype wire

// ### hw/dsp_data_alu_mac.sv
/*
  Data arithmetic datapath: four input words, two 56-bit accumulators,
  a two-stage multiply-accumulate pipe, a barrel shifter and two bus
  shifter/limiters. Assumes instruction control issues at most one
  operation per clock and drives the two memory data bus ports.
*/
`timescale 1ns/1ns
`default_nettype none
module dsp_data_alu_mac
  import dsp_dalu_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Mode
  input wire logic i_mode16,
  input wire logic [1:0] i_scale,
  // Instruction issue
  input wire logic i_op_valid,
  input wire logic [3:0] i_op_code,
  input wire logic i_op_cond,
  input wire logic [2:0] i_op_src1,
  input wire logic [2:0] i_op_src2,
  input wire logic i_op_dst,
  input wire logic [1:0] i_op_sign,
  input wire logic i_op_round,
  input wire logic i_op_shift_left,
  input wire logic [SHIFT_W-1:0] i_op_shift_amt,
  // First memory data bus
  input wire logic i_xbus_wr,
  input wire logic [3:0] i_xbus_wsel,
  input wire logic [23:0] i_xbus_wdata,
  input wire logic [3:0] i_xbus_rsel,
  output logic [23:0] o_xbus_rdata,
  output logic o_xbus_limited,
  // Second memory data bus
  input wire logic i_ybus_wr,
  input wire logic [3:0] i_ybus_wsel,
  input wire logic [23:0] i_ybus_wdata,
  input wire logic [3:0] i_ybus_rsel,
  output logic [23:0] o_ybus_rdata,
  output logic o_ybus_limited,
  // Results
  output logic [55:0] o_acc_one,
  output logic [55:0] o_acc_two,
  output logic o_result_valid
);
  // ==========================================================
  // Helpers
  function automatic logic [23:0] fit(input logic [23:0] w, input logic m16);
    return m16 ? (w & MODE16_MASK) : w;
  endfunction

  function automatic logic [55:0] frac_mul(input logic [23:0] a, input logic [23:0] b,
                                           input logic [1:0] sg);
    logic signed [24:0] ea;
    logic signed [24:0] eb;
    logic signed [49:0] p;
    ea = {(sg != SGN_UU) & a[23], a};
    eb = {(sg == SGN_SS) & b[23], b};
    p = ea * eb;
    // Fractional: one left shift, then sign-extend the 48-bit product
    return {{6{p[49]}}, p[48:0], 1'b0};
  endfunction

  function automatic logic [55:0] round_acc(input logic [55:0] v, input logic m16);
    return m16 ? ((v + RND_ADD_16) & RND_MASK_16) : ((v + RND_ADD_24) & RND_MASK_24);
  endfunction

  function automatic logic [SHIFT_W-1:0] norm_count(input logic [55:0] v);
    logic [SHIFT_W-1:0] n;
    logic run;
    n = '0;
    run = 1'b1;
    for (int i = 54; i >= 0; i--) begin
      if (run && (v[i] == v[55])) begin
        n = n + 1'b1;
      end else begin
        run = 1'b0;
      end
    end
    return n;
  endfunction

  function automatic logic sel_acc_two(input logic [3:0] s);
    return (s == SEL_ACC_TWO_EXTENSION) || (s == SEL_ACC_TWO_HIGH) || (s == SEL_ACC_TWO_LOW)
        || (s == SEL_ACC_TWO) || (s == SEL_ACC_TWO_LIM_LOW);
  endfunction

  // ==========================================================
  // State
  logic [23:0] input_q [4];
  logic [23:0] input_d [4];
  logic [55:0] acc_q [2];
  logic [55:0] acc_d [2];
  logic s2_valid_q, s2_valid_d;
  dalu_op_e s2_op_q, s2_op_d;
  logic s2_dst_q, s2_dst_d;
  logic s2_round_q, s2_round_d;
  logic s2_shl_q, s2_shl_d;
  logic [SHIFT_W-1:0] s2_amt_q, s2_amt_d;
  logic [55:0] s2_opa_q, s2_opa_d;
  logic [55:0] s2_prod_q, s2_prod_d;
  logic [55:0] res;
  logic [55:0] acc_fwd [2];
  logic [23:0] lim_high [2];
  logic [23:0] lim_low [2];
  logic lim_flag [2];
  logic [23:0] rdata_q [2];
  logic [23:0] rdata_d [2];
  logic limited_q [2];
  logic limited_d [2];
  logic bwr [2];
  logic [3:0] bwsel [2];
  logic [23:0] bwdata [2];
  logic [3:0] brsel [2];

  assign bwr[0] = i_xbus_wr;
  assign bwr[1] = i_ybus_wr;
  assign bwsel[0] = i_xbus_wsel;
  assign bwsel[1] = i_ybus_wsel;
  assign bwdata[0] = i_xbus_wdata;
  assign bwdata[1] = i_ybus_wdata;
  assign brsel[0] = i_xbus_rsel;
  assign brsel[1] = i_ybus_rsel;

  // ==========================================================
  // Stage two: accumulate, shift, round
  always_comb begin
    logic [55:0] base;
    base = acc_q[s2_dst_q];
    case (s2_op_q)
      OP_MPY: res = s2_prod_q;
      OP_MAC: res = base + s2_prod_q;
      OP_ADD: res = base + s2_opa_q;
      OP_SUB: res = base - s2_opa_q;
      OP_TFR: res = s2_opa_q;
      OP_SHIFT: res = s2_shl_q ? (base << s2_amt_q) : ($signed(base) >>> s2_amt_q);
      OP_NORM: res = base << norm_count(base);
      OP_CLR: res = ACC_RST;
      default: res = base;
    endcase
    // Truncation is the default; rounding only on request
    if (s2_round_q || (s2_op_q == OP_RND)) begin
      res = round_acc(res, i_mode16);
    end
  end

  // Forwarding path so a fresh result is a source next cycle
  always_comb begin
    for (int a = 0; a < 2; a++) begin
      acc_fwd[a] = (s2_valid_q && (s2_dst_q == a[0])) ? res : acc_q[a];
    end
  end

  // ==========================================================
  // Stage one: operand fetch and multiply
  always_comb begin
    logic [23:0] w;
    w = input_q[i_op_src1[1:0]];
    s2_valid_d = i_op_valid && i_op_cond && (i_op_code != OP_NOP);
    s2_op_d = dalu_op_e'(i_op_code);
    s2_dst_d = i_op_dst;
    s2_round_d = i_op_round;
    s2_shl_d = i_op_shift_left;
    s2_amt_d = i_op_shift_amt;
    // Sources are registers only; no memory path reaches here
    if (i_op_src1 == SRC_ACC_ONE) begin
      s2_opa_d = acc_fwd[0];
    end else if (i_op_src1 == SRC_ACC_TWO) begin
      s2_opa_d = acc_fwd[1];
    end else if (i_op_src1 == SRC_FIRST_PAIR) begin
      s2_opa_d = {{8{input_q[0][23]}}, input_q[0], input_q[1]};
    end else if (i_op_src1 == SRC_SECOND_PAIR) begin
      s2_opa_d = {{8{input_q[2][23]}}, input_q[2], input_q[3]};
    end else begin
      s2_opa_d = {{8{w[23]}}, w, WORD_RST};
    end
    s2_prod_d = frac_mul(input_q[i_op_src1[1:0]], input_q[i_op_src2[1:0]], i_op_sign);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s2_valid_q <= 1'b0;
      s2_op_q <= OP_NOP;
      s2_dst_q <= 1'b0;
      s2_round_q <= 1'b0;
      s2_shl_q <= 1'b0;
      s2_amt_q <= '0;
      s2_opa_q <= ACC_RST;
      s2_prod_q <= ACC_RST;
    end else begin
      s2_valid_q <= s2_valid_d;
      s2_op_q <= s2_op_d;
      s2_dst_q <= s2_dst_d;
      s2_round_q <= s2_round_d;
      s2_shl_q <= s2_shl_d;
      s2_amt_q <= s2_amt_d;
      s2_opa_q <= s2_opa_d;
      s2_prod_q <= s2_prod_d;
    end
  end

  // ==========================================================
  // Register file: bus writes, then the pipe result wins
  always_comb begin
    logic [23:0] w;
    logic a;
    w = WORD_RST;
    a = 1'b0;
    input_d = input_q;
    acc_d = acc_q;
    // Second bus applied last so a 48-bit move lands low after high
    for (int b = 0; b < 2; b++) begin
      w = fit(bwdata[b], i_mode16);
      a = sel_acc_two(bwsel[b]);
      if (!bwr[b]) begin
        w = WORD_RST;
      end else if (bwsel[b] <= SEL_SECOND_INPUT_LOW) begin
        input_d[bwsel[b][1:0]] = w;
      end else if ((bwsel[b] == SEL_ACC_ONE_EXTENSION) || (bwsel[b] == SEL_ACC_TWO_EXTENSION)) begin
        acc_d[a][55:48] = w[7:0];
      end else if ((bwsel[b] == SEL_ACC_ONE_HIGH) || (bwsel[b] == SEL_ACC_TWO_HIGH)) begin
        acc_d[a][47:24] = w;
      end else if ((bwsel[b] == SEL_ACC_ONE_LOW) || (bwsel[b] == SEL_ACC_TWO_LOW)) begin
        acc_d[a][23:0] = w;
      end else if ((bwsel[b] == SEL_ACC_ONE) || (bwsel[b] == SEL_ACC_TWO)) begin
        acc_d[a] = {{8{w[23]}}, w, WORD_RST};
      end
    end
    if (s2_valid_q) begin
      acc_d[s2_dst_q] = res;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 4; i++) begin
        input_q[i] <= WORD_RST;
      end
      acc_q[0] <= ACC_RST;
      acc_q[1] <= ACC_RST;
    end else begin
      input_q <= input_d;
      acc_q <= acc_d;
    end
  end

  // ==========================================================
  // Bus reads; whole-accumulator selects go through the two shifter/limiters
  for (genvar g = 0; g < 2; g++) begin : g_lim
    dalu_bus_limiter u_lim (
      .i_acc(acc_q[sel_acc_two(brsel[g])]),
      .i_scale(i_scale),
      .i_mode16(i_mode16),
      .o_high(lim_high[g]),
      .o_low(lim_low[g]),
      .o_limited(lim_flag[g])
    );
  end

  always_comb begin
    logic [55:0] v;
    v = ACC_RST;
    for (int b = 0; b < 2; b++) begin
      v = acc_q[sel_acc_two(brsel[b])];
      limited_d[b] = 1'b0;
      if (brsel[b] <= SEL_SECOND_INPUT_LOW) begin
        rdata_d[b] = fit(input_q[brsel[b][1:0]], i_mode16);
      end else if ((brsel[b] == SEL_ACC_ONE_EXTENSION) || (brsel[b] == SEL_ACC_TWO_EXTENSION)) begin
        rdata_d[b] = {{16{v[55]}}, v[55:48]};
      end else if ((brsel[b] == SEL_ACC_ONE_HIGH) || (brsel[b] == SEL_ACC_TWO_HIGH)) begin
        rdata_d[b] = fit(v[47:24], i_mode16);
      end else if ((brsel[b] == SEL_ACC_ONE_LOW) || (brsel[b] == SEL_ACC_TWO_LOW)) begin
        rdata_d[b] = fit(v[23:0], i_mode16);
      end else if ((brsel[b] == SEL_ACC_ONE) || (brsel[b] == SEL_ACC_TWO)) begin
        rdata_d[b] = lim_high[b];
        limited_d[b] = lim_flag[b];
      end else if ((brsel[b] == SEL_ACC_ONE_LIM_LOW) || (brsel[b] == SEL_ACC_TWO_LIM_LOW)) begin
        rdata_d[b] = lim_low[b];
        limited_d[b] = lim_flag[b];
      end else begin
        rdata_d[b] = WORD_RST;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_q[0] <= WORD_RST;
      rdata_q[1] <= WORD_RST;
      limited_q[0] <= 1'b0;
      limited_q[1] <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      limited_q <= limited_d;
    end
  end

  assign o_xbus_rdata = rdata_q[0];
  assign o_ybus_rdata = rdata_q[1];
  assign o_xbus_limited = limited_q[0];
  assign o_ybus_limited = limited_q[1];
  assign o_acc_one = acc_q[0];
  assign o_acc_two = acc_q[1];
  assign o_result_valid = s2_valid_q;

  // ==========================================================
  // Checks
  AST_PIPE_ISSUE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_op_valid && i_op_cond && (i_op_code != OP_NOP) ##1 i_op_valid && i_op_cond && (i_op_code != OP_NOP)
    |-> o_result_valid ##1 o_result_valid) else $error("back-to-back issue lost a result");
  AST_SQUASH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_op_valid && !i_op_cond |=> !o_result_valid) else $error("failed condition still wrote");
  AST_FORWARD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s2_valid_q && !s2_dst_q && i_op_valid && i_op_cond && (i_op_src1 == SRC_ACC_ONE)
    |=> s2_opa_q == acc_q[0]) else $error("forwarded operand is stale");
  AST_MAC_SUM: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s2_valid_q && (s2_op_q == OP_MAC) && !s2_round_q
    |=> acc_q[$past(s2_dst_q)] == $past(acc_q[s2_dst_q]) + $past(s2_prod_q)) else $error("product not accumulated");
  AST_ROUND_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s2_valid_q && s2_round_q && !i_mode16 |=> acc_q[$past(s2_dst_q)][23:0] == 24'h000000)
    else $error("rounded result kept low part");
  AST_INPUT_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_xbus_wr && !(i_ybus_wr && (i_ybus_wsel == SEL_FIRST_INPUT_HIGH)) && (i_xbus_wsel == SEL_FIRST_INPUT_HIGH) && !i_mode16
    |=> input_q[0] == $past(i_xbus_wdata)) else $error("input word not written");
  AST_MODE16: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_mode16 && i_xbus_wr && (i_xbus_wsel == SEL_FIRST_INPUT_HIGH)
    |=> input_q[0][7:0] == 8'h00) else $error("16-bit write kept low byte");
  AST_ACC_ONLY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_xbus_wr && !i_ybus_wr |=> $stable(input_q[0]) && $stable(input_q[1]) && $stable(input_q[2])
    && $stable(input_q[3])) else $error("operation wrote an input word");
  AST_LIMIT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_xbus_limited && !$past(i_mode16) && ($past(i_xbus_rsel) == SEL_ACC_ONE)
    |-> (o_xbus_rdata == LIM_POS_HIGH) || (o_xbus_rdata == LIM_NEG_HIGH)) else $error("limit value wrong");
endmodule
`default_nettype wire

// ### test/dalu_ctrl_model.sv
/*
  Instruction control model: issues operations and sets the arithmetic mode.
  Assumes one caller at a time and drives only just after rising edges.
*/
`timescale 1ns/1ns
`default_nettype none
module dalu_ctrl_model
  import dsp_dalu_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Mode
  output logic o_mode16,
  output logic [1:0] o_scale,
  // Issue
  output logic o_valid,
  output logic [3:0] o_code,
  output logic o_cond,
  output logic [2:0] o_src1,
  output logic [2:0] o_src2,
  output logic o_dst,
  output logic [1:0] o_sign,
  output logic o_round,
  output logic o_shift_left,
  output logic [SHIFT_W-1:0] o_shift_amt
);
  // ==========================================================
  // Idle values
  initial begin
    o_mode16 = 1'b0;
    o_scale = SCALE_NONE;
    o_valid = 1'b0;
    o_code = OP_NOP;
    o_cond = 1'b0;
    o_src1 = 3'h0;
    o_src2 = 3'h0;
    o_dst = 1'b0;
    o_sign = SGN_SS;
    o_round = 1'b0;
    o_shift_left = 1'b0;
    o_shift_amt = '0;
  end

  // ==========================================================
  // Mode change
  task automatic set_mode(input logic m16, input logic [1:0] sc);
    @(posedge i_clk);
    o_mode16 <= m16;
    o_scale <= sc;
  endtask

  // Shift fields held for the following issues
  task automatic set_shift(input logic left, input logic [SHIFT_W-1:0] n);
    @(posedge i_clk);
    o_shift_left <= left;
    o_shift_amt <= n;
  endtask

  // ==========================================================
  // Issue; left asserted so a second call issues back to back
  task automatic issue(input logic [3:0] code, input logic cond, input logic [2:0] s1,
                       input logic [2:0] s2, input logic dst, input logic [1:0] sg,
                       input logic rnd);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_code <= code;
    o_cond <= cond;
    o_src1 <= s1;
    o_src2 <= s2;
    o_dst <= dst;
    o_sign <= sg;
    o_round <= rnd;
  endtask

  // Unkind idle: selects flip so stale fields never look valid
  task automatic quiet;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_code <= ~o_code;
    o_src1 <= ~o_src1;
    o_src2 <= ~o_src2;
  endtask
endmodule
`default_nettype wire

// ### test/dsp_data_alu_mac_tb.sv
/*
  Bench for the data arithmetic datapath: directed scenarios through the
  control model and both memory data bus ports. Assumes the package exists.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module dsp_data_alu_mac_tb
  import dsp_dalu_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic mode16, op_valid, op_cond, op_dst, op_round, shl;
  logic [1:0] scale, op_sign;
  logic [3:0] op_code;
  logic [2:0] src1, src2;
  logic [SHIFT_W-1:0] amt;
  logic xwr, ywr, xlim, ylim, rvalid;
  logic [3:0] xws, yws, xrs, yrs;
  logic [23:0] xwd, ywd, xrd, yrd;
  logic [55:0] acc1, acc2;
  int error_cnt = 0;
  int checks = 0;
  int vcount = 0;

  // ==========================================================
  // Clock, model and design
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (rvalid === 1'b1) begin
      vcount++;
    end
  end

  dalu_ctrl_model m_u (.i_clk(i_clk), .o_mode16(mode16), .o_scale(scale), .o_valid(op_valid),
    .o_code(op_code), .o_cond(op_cond), .o_src1(src1), .o_src2(src2), .o_dst(op_dst),
    .o_sign(op_sign), .o_round(op_round), .o_shift_left(shl), .o_shift_amt(amt));

  dsp_data_alu_mac dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_mode16(mode16), .i_scale(scale),
    .i_op_valid(op_valid), .i_op_code(op_code), .i_op_cond(op_cond), .i_op_src1(src1),
    .i_op_src2(src2), .i_op_dst(op_dst), .i_op_sign(op_sign), .i_op_round(op_round),
    .i_op_shift_left(shl), .i_op_shift_amt(amt), .i_xbus_wr(xwr), .i_xbus_wsel(xws),
    .i_xbus_wdata(xwd), .i_xbus_rsel(xrs), .o_xbus_rdata(xrd), .o_xbus_limited(xlim),
    .i_ybus_wr(ywr), .i_ybus_wsel(yws), .i_ybus_wdata(ywd), .i_ybus_rsel(yrs),
    .o_ybus_rdata(yrd), .o_ybus_limited(ylim), .o_acc_one(acc1), .o_acc_two(acc2),
    .o_result_valid(rvalid));

  // ==========================================================
  // Bus and result helpers
  task automatic wr(input logic xe, input logic [3:0] xs, input logic [23:0] xd,
                    input logic ye, input logic [3:0] ys, input logic [23:0] yd);
    @(posedge i_clk);
    xwr <= xe;
    xws <= xs;
    xwd <= xd;
    ywr <= ye;
    yws <= ys;
    ywd <= yd;
    @(posedge i_clk);
    xwr <= 1'b0;
    ywr <= 1'b0;
    xwd <= ~xd;
    ywd <= ~yd;
  endtask

  task automatic rd(input logic [3:0] xs, input logic [3:0] ys, input logic [23:0] xe,
                    input logic [23:0] ye, input logic le);
    @(posedge i_clk);
    xrs <= xs;
    yrs <= ys;
    @(posedge i_clk);
    #1;
    `CHK("x_rdata", xe, xrd)
    `CHK("y_rdata", ye, yrd)
    `CHK("x_limited", le, xlim)
    `CHK("y_limited", le, ylim)
  endtask

  // Bounded wait for stage two, then the accumulators one edge later
  task automatic settle(input logic [55:0] e1, input logic [55:0] e2);
    int n;
    n = 0;
    #1;
    while (rvalid !== 1'b1 && n < 8) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    `CHK("result_valid", 1'b1, rvalid)
    @(posedge i_clk);
    #1;
    `CHK("acc_one", e1, acc1)
    `CHK("acc_two", e2, acc2)
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_inputs;
    wr(1'b1, SEL_FIRST_INPUT_HIGH, 24'h800000, 1'b1, SEL_SECOND_INPUT_HIGH, 24'hc00000);
    wr(1'b1, SEL_FIRST_INPUT_LOW, 24'h123456, 1'b1, SEL_SECOND_INPUT_LOW, 24'habcdef);
    rd(SEL_FIRST_INPUT_HIGH, SEL_SECOND_INPUT_HIGH, 24'h800000, 24'hc00000, 1'b0);
    rd(SEL_FIRST_INPUT_LOW, SEL_SECOND_INPUT_LOW, 24'h123456, 24'habcdef, 1'b0);
  endtask

  // Same operands under all three signedness codes
  task automatic t_sign;
    logic [55:0] want [3];
    want = '{56'h00400000000000, 56'hff400000000000, 56'h00c00000000000};
    for (int s = 0; s < 3; s++) begin
      m_u.issue(OP_MPY, 1'b1, 3'h0, 3'h2, 1'b0, s[1:0], 1'b0);
      m_u.quiet();
      settle(want[s], ACC_RST);
    end
  endtask

  // Accumulator one holds 1.5 here, so it must saturate unscaled
  task automatic t_limit;
    rd(SEL_ACC_ONE, SEL_ACC_ONE_LIM_LOW, 24'h7fffff, 24'hffffff, 1'b1);
    m_u.set_mode(1'b0, SCALE_DOWN);
    rd(SEL_ACC_ONE, SEL_ACC_ONE_LIM_LOW, 24'h600000, 24'h000000, 1'b0);
    wr(1'b1, SEL_ACC_TWO, 24'h800000, 1'b0, SEL_FIRST_INPUT_LOW, 24'h0);
    #1;
    `CHK("acc_two", 56'hff800000000000, acc2)
    m_u.set_mode(1'b0, SCALE_UP);
    rd(SEL_ACC_TWO, SEL_ACC_TWO_LIM_LOW, 24'h800000, 24'h000000, 1'b1);
    m_u.set_mode(1'b0, SCALE_NONE);
  endtask

  // Back to back; the second reads the first one's result
  task automatic t_pipe;
    vcount = 0;
    m_u.issue(OP_MPY, 1'b1, 3'h0, 3'h2, 1'b1, SGN_SS, 1'b0);
    m_u.issue(OP_MAC, 1'b1, 3'h0, 3'h2, 1'b1, SGN_SS, 1'b0);
    m_u.quiet();
    settle(56'h00c00000000000, 56'h00800000000000);
    `CHK("result_count", 2, vcount)
    // Accumulator operand needs the forwarded product
    m_u.issue(OP_MPY, 1'b1, 3'h0, 3'h2, 1'b0, SGN_SS, 1'b0);
    m_u.issue(OP_ADD, 1'b1, SRC_ACC_ONE, 3'h2, 1'b1, SGN_SS, 1'b0);
    m_u.quiet();
    settle(56'h00400000000000, 56'h00c00000000000);
  endtask

  task automatic t_round;
    wr(1'b1, SEL_FIRST_INPUT_LOW, 24'h400001, 1'b1, SEL_SECOND_INPUT_LOW, 24'h400000);
    m_u.issue(OP_MPY, 1'b1, 3'h1, 3'h3, 1'b0, SGN_SS, 1'b0);
    m_u.quiet();
    settle(56'h00200000800000, 56'h00c00000000000);
    m_u.issue(OP_MPY, 1'b1, 3'h1, 3'h3, 1'b0, SGN_SS, 1'b1);
    m_u.quiet();
    settle(56'h00200001000000, 56'h00c00000000000);
  endtask

  // A false condition and a no-op leave everything untouched
  task automatic t_squash;
    vcount = 0;
    m_u.issue(OP_MPY, 1'b0, 3'h0, 3'h2, 1'b0, SGN_SS, 1'b0);
    m_u.issue(OP_NOP, 1'b1, 3'h0, 3'h2, 1'b1, SGN_SS, 1'b0);
    m_u.quiet();
    repeat (5) @(posedge i_clk);
    #1;
    `CHK("result_count", 0, vcount)
    `CHK("acc_one", 56'h00200001000000, acc1)
  endtask

  task automatic t_mode16;
    m_u.set_mode(1'b1, SCALE_NONE);
    wr(1'b1, SEL_FIRST_INPUT_HIGH, 24'h123456, 1'b1, SEL_SECOND_INPUT_HIGH, 24'habcdef);
    rd(SEL_FIRST_INPUT_HIGH, SEL_SECOND_INPUT_HIGH, 24'h123400, 24'habcd00, 1'b0);
    m_u.set_mode(1'b0, SCALE_NONE);
  endtask

  // Shifts, normalize, subtract, pair transfer, round and clear in turn
  task automatic t_ops;
    m_u.set_shift(1'b0, 6'h04);
    m_u.issue(OP_SHIFT, 1'b1, 3'h0, 3'h2, 1'b0, SGN_SS, 1'b0);
    m_u.quiet();
    settle(56'h00020000100000, 56'h00c00000000000);
    m_u.issue(OP_NORM, 1'b1, 3'h0, 3'h2, 1'b0, SGN_SS, 1'b0);
    m_u.quiet();
    settle(56'h40000200000000, 56'h00c00000000000);
    // Left shift drops what leaves the top
    m_u.set_shift(1'b1, 6'h04);
    m_u.issue(OP_SHIFT, 1'b1, 3'h0, 3'h2, 1'b0, SGN_SS, 1'b0);
    m_u.quiet();
    settle(56'h00002000000000, 56'h00c00000000000);
    m_u.issue(OP_SUB, 1'b1, SRC_ACC_ONE, 3'h2, 1'b1, SGN_SS, 1'b0);
    m_u.quiet();
    settle(56'h00002000000000, 56'h00bfe000000000);
    m_u.issue(OP_TFR, 1'b1, SRC_SECOND_PAIR, 3'h2, 1'b0, SGN_SS, 1'b0);
    m_u.quiet();
    settle(56'hffabcd00400000, 56'h00bfe000000000);
    m_u.issue(OP_RND, 1'b1, 3'h0, 3'h2, 1'b0, SGN_SS, 1'b0);
    m_u.quiet();
    settle(56'hffabcd00000000, 56'h00bfe000000000);
    m_u.issue(OP_CLR, 1'b1, 3'h0, 3'h2, 1'b1, SGN_SS, 1'b0);
    m_u.quiet();
    settle(56'hffabcd00000000, ACC_RST);
  endtask

  // ==========================================================
  // Verdict
  task automatic results;
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole run is under a hundred cycles; this allows over fifty times that
  initial begin
    #(100 * 5000);
    error_cnt++;
    results();
  end

  initial begin
    xwr = 1'b0;
    ywr = 1'b0;
    xws = 4'h0;
    yws = 4'h0;
    xwd = 24'h000000;
    ywd = 24'h000000;
    xrs = 4'h0;
    yrs = 4'h0;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    #1;
    `CHK("acc_one", ACC_RST, acc1)
    `CHK("acc_two", ACC_RST, acc2)
    t_inputs();
    t_sign();
    t_limit();
    t_pipe();
    t_round();
    t_squash();
    t_mode16();
    t_ops();
    results();
  end
endmodule
`default_nettype wire
